// ---- common/adc_sleep_pkg.sv ----
// constants, field layouts and types for the sleep-triggered conversion controller
// assumes a 20 MHz system clock and an APB master with 32-bit data
// How it works
// RULE1 - software readies converter before sleeping
// RULE2 - idle/noise sleep starts conversion at halt
// RULE3 - completion with no other interrupt wakes CPU
// RULE4 - other wake first; completion still raises request
// RULE5 - no restart until next sleep entry
// RULE6 - other sleep modes leave enable untouched
// RULE7 - software clears enable before other sleeps
// RULE8 - re-enable after such sleep requests extended conversion
// RULE9 - shared pins stay quiet during conversion
// RULE10 - halt starts conversion only if enabled and idle
package adc_sleep_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_MASK   = 8'h0C;

    // control field positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_FREE_RUN    = 1;
    localparam int CTRL_IRQ_EN      = 2;
    localparam int CTRL_START       = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // interrupt status bits, same layout in the mask
    localparam int INT_DONE       = 0;
    localparam int INT_WAKE_ADC   = 1;
    localparam int INT_WAKE_OTHER = 2;
    localparam int INT_W          = 3;
    localparam logic [2:0] INT_RESET = 3'h0;

    // sleep mode codes seen from the sleep controller
    localparam logic [2:0] MODE_IDLE  = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;

    // control register contents
    typedef struct packed {
        logic start;            // write-one manual start, self clearing
        logic irq_en;           // conversion-complete interrupt enable
        logic free_run;         // 0 selects single conversion
        logic converter_enable_bit;
    } ctrl_t;

    // sleep conversion sequencer
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,     // awake or no sleep conversion running
        SEQ_SLEEP  = 2'b01,     // conversion running with cpu halted
        SEQ_AWAKE  = 2'b10,     // woken by another source, still converting
        SEQ_REST   = 2'b11      // done; wait for cpu to leave the halt
    } seq_t;

endpackage

// ---- src/adc_sleep_noise_canceler.sv ----
// sleep-triggered conversion control with APB registers and interrupt
// assumes the converter core pulses done for one cycle and holds busy while converting
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module adc_sleep_noise_canceler
(
    input  wire logic        clk_in,            // 20 MHz system clock
    input  wire logic        rst_n_in,          // asynchronous active-low reset
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        cpu_halted_in,     // high while the core is halted by sleep
    input  wire logic [2:0]  sleep_mode_in,     // sleep mode selected for this halt
    input  wire logic        other_wake_in,     // a different interrupt woke the core
    input  wire logic        irq_ack_in,        // core took the conversion-complete vector
    input  wire logic        conv_busy_in,      // converter core is converting
    input  wire logic        conv_done_in,      // one-cycle completion pulse
    output logic             conv_start_out,    // one-cycle start pulse to the core
    output logic             conv_extended_out, // start is an extended conversion
    output logic             conv_enable_out,   // converter enable level
    output logic             cpu_wake_out,      // one-cycle wake pulse to sleep control
    output logic             conv_irq_req_out,  // pending conversion-complete request
    output logic             irq_out            // masked status interrupt
);

    // reset synchroniser stages
    logic        rst_meta_r;
    logic        rst_sync_r;

    // register state
    adc_sleep_pkg::ctrl_t ctrl_r;               // control register
    logic [adc_sleep_pkg::INT_W-1:0] int_stat_r; // sticky events
    logic [adc_sleep_pkg::INT_W-1:0] int_mask_r; // event mask
    adc_sleep_pkg::seq_t  seq_r;                // sleep sequencer
    adc_sleep_pkg::seq_t  seq_nxt;
    logic        halted_d_r;                    // halt level one cycle ago
    logic        enable_d_r;                    // enable level one cycle ago
    logic        ext_pend_r;                    // next start must be extended
    logic        other_sleep_r;                 // enable stayed on through other sleep

    // decoded access strobes plus halt, mode, busy, start and event terms
    logic        access;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_mask;
    logic        halt_rise;
    logic        sleep_ok;
    logic        busy;
    logic        auto_start;
    logic        man_start;
    logic [adc_sleep_pkg::INT_W-1:0] int_set;

    // release the reset through two stages so removal is clean
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // one wait state: the access phase ends on its second cycle
    assign access  = psel_in & penable_in & ~pready_out;
    assign wr_ctrl = access & pwrite_in & (paddr_in == adc_sleep_pkg::OFS_CTRL);
    assign wr_stat = access & pwrite_in & (paddr_in == adc_sleep_pkg::OFS_INT_STATUS);
    assign wr_mask = access & pwrite_in & (paddr_in == adc_sleep_pkg::OFS_INT_MASK);

    // own start counts as busy until the core raises its flag
    assign busy      = conv_busy_in | conv_start_out;
    assign halt_rise = cpu_halted_in & ~halted_d_r;
    // only the two quiet modes are served
    assign sleep_ok  = (sleep_mode_in == adc_sleep_pkg::MODE_IDLE) |
                       (sleep_mode_in == adc_sleep_pkg::MODE_NOISE); // RULE2
    // a fresh halt edge is needed, so a woken core never restarts by itself
    assign auto_start = halt_rise & sleep_ok & ctrl_r.converter_enable_bit &
                        ~ctrl_r.free_run & ~busy & (seq_r == adc_sleep_pkg::SEQ_IDLE); // RULE10 RULE5
    assign man_start  = wr_ctrl & pwdata_in[adc_sleep_pkg::CTRL_START] &
                        pwdata_in[adc_sleep_pkg::CTRL_ENABLE_BIT] & ~busy;

    // bus answer, registered; unmapped addresses answer with an error
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= access;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            if (access)
            begin
                unique case (paddr_in)
                    adc_sleep_pkg::OFS_CTRL:       prdata_out <= {28'h000_0000, 1'b0, ctrl_r.irq_en,
                                                                  ctrl_r.free_run, ctrl_r.converter_enable_bit};
                    adc_sleep_pkg::OFS_STATUS:     prdata_out <= {29'h0000_0000, ext_pend_r,
                                                                  (seq_r != adc_sleep_pkg::SEQ_IDLE), busy};
                    adc_sleep_pkg::OFS_INT_STATUS: prdata_out <= {29'h0000_0000, int_stat_r};
                    adc_sleep_pkg::OFS_INT_MASK:   prdata_out <= {29'h0000_0000, int_mask_r};
                    default:                       pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    // control register; hardware never touches the enable, whatever the sleep mode
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            ctrl_r <= adc_sleep_pkg::CTRL_RESET;
        else if (wr_ctrl)
        begin
            ctrl_r.converter_enable_bit <= pwdata_in[adc_sleep_pkg::CTRL_ENABLE_BIT]; // RULE6
            ctrl_r.free_run             <= pwdata_in[adc_sleep_pkg::CTRL_FREE_RUN];
            ctrl_r.irq_en               <= pwdata_in[adc_sleep_pkg::CTRL_IRQ_EN];
            ctrl_r.start                <= 1'b0;
        end
    end

    // remember an enable left on across a non-quiet sleep, then flag the re-enable
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            halted_d_r    <= 1'b0;
            enable_d_r    <= 1'b0;
            other_sleep_r <= 1'b0;
            ext_pend_r    <= 1'b0;
        end
        else
        begin
            halted_d_r <= cpu_halted_in;
            enable_d_r <= ctrl_r.converter_enable_bit;
            if (halt_rise & ~sleep_ok & ctrl_r.converter_enable_bit)
                other_sleep_r <= 1'b1;               // RULE8
            else if (ctrl_r.converter_enable_bit & ~enable_d_r)
                other_sleep_r <= 1'b0;
            // re-enable after such a sleep asks for an extended first conversion
            if (ctrl_r.converter_enable_bit & ~enable_d_r & other_sleep_r)
                ext_pend_r <= 1'b1;                  // RULE8
            else if (conv_start_out | ~ctrl_r.converter_enable_bit)
                ext_pend_r <= 1'b0;
        end
    end

    // start pulse and its extended qualifier
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            conv_start_out    <= 1'b0;
            conv_extended_out <= 1'b0;
        end
        else
        begin
            conv_start_out    <= auto_start | man_start; // RULE2
            conv_extended_out <= (auto_start | man_start) & ext_pend_r;
        end
    end

    // sequencer next state
    always_comb
    begin
        seq_nxt = seq_r;
        unique case (seq_r)
            adc_sleep_pkg::SEQ_IDLE:
                if (auto_start)
                    seq_nxt = adc_sleep_pkg::SEQ_SLEEP;
            adc_sleep_pkg::SEQ_SLEEP:
                if (conv_done_in)
                    seq_nxt = adc_sleep_pkg::SEQ_REST;      // RULE3
                else if (other_wake_in | ~cpu_halted_in)
                    seq_nxt = adc_sleep_pkg::SEQ_AWAKE;     // RULE4
            adc_sleep_pkg::SEQ_AWAKE:
                if (conv_done_in)
                    seq_nxt = adc_sleep_pkg::SEQ_REST;      // RULE4
            adc_sleep_pkg::SEQ_REST:
                if (~cpu_halted_in)
                    seq_nxt = adc_sleep_pkg::SEQ_IDLE;      // RULE5
        endcase
    end

    // sequencer state
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            seq_r <= adc_sleep_pkg::SEQ_IDLE;
        else
            seq_r <= seq_nxt;
    end

    // wake only when the completion beats every other source
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            cpu_wake_out <= 1'b0;
        else
            cpu_wake_out <= (seq_r == adc_sleep_pkg::SEQ_SLEEP) & conv_done_in &
                            ~other_wake_in & ctrl_r.irq_en; // RULE3
    end

    // completion request toward the core; a new completion beats the ack
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            conv_irq_req_out <= 1'b0;
        else if (conv_done_in & ctrl_r.irq_en)
            conv_irq_req_out <= 1'b1;               // RULE3 RULE4
        else if (irq_ack_in)
            conv_irq_req_out <= 1'b0;
    end

    // sticky events; set wins over a write-one clear in the same cycle
    assign int_set[adc_sleep_pkg::INT_DONE]       = conv_done_in;
    assign int_set[adc_sleep_pkg::INT_WAKE_ADC]   = (seq_r == adc_sleep_pkg::SEQ_SLEEP) &
                                                    conv_done_in & ~other_wake_in;
    assign int_set[adc_sleep_pkg::INT_WAKE_OTHER] = (seq_r == adc_sleep_pkg::SEQ_SLEEP) &
                                                    ~conv_done_in & (other_wake_in | ~cpu_halted_in);

    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            int_stat_r <= adc_sleep_pkg::INT_RESET;
        else if (wr_stat)
            int_stat_r <= (int_stat_r & ~pwdata_in[adc_sleep_pkg::INT_W-1:0]) | int_set;
        else
            int_stat_r <= int_stat_r | int_set;
    end

    // mask register
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            int_mask_r <= adc_sleep_pkg::INT_RESET;
        else if (wr_mask)
            int_mask_r <= pwdata_in[adc_sleep_pkg::INT_W-1:0];
    end

    // registered level outputs
    always_ff @(posedge clk_in or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            irq_out         <= 1'b0;
            conv_enable_out <= 1'b0;
        end
        else
        begin
            irq_out         <= |(int_stat_r & int_mask_r);
            conv_enable_out <= ctrl_r.converter_enable_bit; // RULE6
        end
    end

endmodule

// ---- dv/adc_sleep_monitor.sv ----
// port assertions for the sleep-triggered conversion controller
// assumes one clock domain; bound to the controller module by the bind below
`timescale 1ns/1ps
module adc_sleep_monitor
(
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       psel_in,
    input wire logic       penable_in,
    input wire logic       pready_out,
    input wire logic       cpu_halted_in,
    input wire logic [2:0] sleep_mode_in,
    input wire logic       other_wake_in,
    input wire logic       irq_ack_in,
    input wire logic       conv_done_in,
    input wire logic       conv_start_out,
    input wire logic       conv_extended_out,
    input wire logic       conv_enable_out,
    input wire logic       cpu_wake_out,
    input wire logic       conv_irq_req_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // bus answer is one pulse, one cycle after the access is taken
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_follows: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready missing after access");
    // three idle bus cycles leave no write in flight
    a_enable_kept: assert property (!psel_in [*3] |=> $stable(conv_enable_out))
        else $error("enable moved without a write");
    // a register-bus access may start a manual conversion, so only quiet awake cycles count
    a_no_restart: assert property (!cpu_halted_in && !penable_in |=> !conv_start_out)
        else $error("start while awake");
    a_other_mode: assert property ($rose(cpu_halted_in) && sleep_mode_in > 3'h1 |=> !conv_start_out)
        else $error("start in other sleep mode");
    a_start_disabled: assert property ($rose(cpu_halted_in) && !conv_enable_out |=> !conv_start_out)
        else $error("start while disabled");
    a_wake_cause: assert property (cpu_wake_out |-> $past(conv_done_in) && !$past(other_wake_in))
        else $error("wake without completion");
    a_req_from_done: assert property ($rose(conv_irq_req_out) |-> $past(conv_done_in))
        else $error("request without completion");
    a_req_sticky: assert property (conv_irq_req_out && !irq_ack_in |=> conv_irq_req_out)
        else $error("request dropped without ack");
    a_ext_with_start: assert property (conv_extended_out |-> conv_start_out)
        else $error("extended flag without start");
endmodule
bind adc_sleep_noise_canceler adc_sleep_monitor chk (.*);

// ---- dv/cpu_sleep_model.sv ----
// model of the halting core and of the converter core
// assumes the bench pulses sleep_go_in and other_go_in for one cycle
`timescale 1ns/1ps
module cpu_sleep_model #(parameter int CONV_CYC = 20)
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sleep_go_in,
    input  wire logic [2:0] mode_go_in,
    input  wire logic       other_go_in,
    input  wire logic       start_in,
    input  wire logic       wake_in,
    input  wire logic       req_in,
    output logic            halted_out,
    output logic      [2:0] mode_out,
    output logic            other_wake_out,
    output logic            ack_out,
    output logic            busy_out,
    output logic            done_out
);
    int cnt_r; // cycles left in the conversion
    // halt on a sleep command, leave it on any wake; stays awake until told
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            halted_out <= 1'b0;
            mode_out <= 3'h0;
            other_wake_out <= 1'b0;
            ack_out <= 1'b0;
        end
        else
        begin
            if (sleep_go_in)
            begin
                halted_out <= 1'b1;
                mode_out <= mode_go_in;
            end
            else if (wake_in || other_go_in)
                halted_out <= 1'b0;
            other_wake_out <= other_go_in && halted_out;
            // vector taken once awake, one pulse only
            ack_out <= req_in && !halted_out && !ack_out;
        end
    end
    // converter core: busy for a fixed count, then one done pulse
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= 0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= (cnt_r == 1);
            busy_out <= start_in || cnt_r > 1;
            cnt_r <= start_in ? CONV_CYC : (cnt_r > 0 ? cnt_r - 1 : 0);
        end
    end
endmodule

// ---- dv/adc_sleep_noise_canceler_tb_top.sv ----
// self-checking bench: apb register tasks plus sleep sequences
// assumes the core model in cpu_sleep_model and the bound monitor
`timescale 1ns/1ps
module adc_sleep_noise_canceler_tb_top;
    localparam int CONV_CYC = 20;
    logic clk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, halted, other, ack, busy, done, start, ext, en, wake, req, irq;
    logic go = 1'b0, ogo = 1'b0;
    logic [2:0] mode, mgo = 3'h0;
    int fails = 0, comparisons = 0, cyc = 0, starts = 0, wakes = 0, exts = 0, reqs = 0;
    logic req_d = 1'b0; // completion request level one edge ago
    adc_sleep_noise_canceler uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cpu_halted_in(halted), .sleep_mode_in(mode), .other_wake_in(other),
        .irq_ack_in(ack), .conv_busy_in(busy), .conv_done_in(done), .conv_start_out(start),
        .conv_extended_out(ext), .conv_enable_out(en), .cpu_wake_out(wake), .conv_irq_req_out(req),
        .irq_out(irq));
    cpu_sleep_model #(.CONV_CYC(CONV_CYC)) core (.clk_in(clk_in), .rst_n_in(rst_n_in), .sleep_go_in(go),
        .mode_go_in(mgo), .other_go_in(ogo), .start_in(start), .wake_in(wake), .req_in(req),
        .halted_out(halted), .mode_out(mode), .other_wake_out(other), .ack_out(ack), .busy_out(busy),
        .done_out(done));
    initial
        forever #25 clk_in = ~clk_in;
    // pulse counters and the hang limit
    always @(posedge clk_in)
    begin
        cyc++;
        starts += int'(start === 1'b1);
        wakes += int'(wake === 1'b1);
        exts += int'(ext === 1'b1);
        // each rise of the request is one completion handed to the core
        reqs += int'(req === 1'b1 && req_d === 1'b0);
        req_d = req;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1)
            @(posedge clk_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // halt in mode m, optionally woken early by another source
    task automatic nap(input logic [2:0] m, input logic oth);
        @(posedge clk_in);
        go <= 1'b1;
        mgo <= m;
        @(posedge clk_in);
        go <= 1'b0;
        if (oth)
        begin
            repeat (5) @(posedge clk_in);
            ogo <= 1'b1;
            @(posedge clk_in);
            ogo <= 1'b0;
        end
        // no bus traffic while the conversion runs, so shared pins stay quiet
        repeat (CONV_CYC + 10) @(posedge clk_in);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rdchk(adc_sleep_pkg::OFS_CTRL, 32'h0, "ctrl reset");
        rdchk(adc_sleep_pkg::OFS_INT_MASK, 32'h0, "mask reset");
        rdchk(8'h10, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, adc_sleep_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, adc_sleep_pkg::OFS_INT_MASK, 32'h7);
        for (int m = 0; m < 2; m++)
        begin
            nap(m[2:0], 1'b0);
            rdchk(adc_sleep_pkg::OFS_INT_STATUS, 32'h3, "woke by done");
            chk("irq set", 32'h1, {31'h0, irq});
            apb(1'b1, adc_sleep_pkg::OFS_INT_STATUS, 32'h3);
            @(negedge clk_in);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        chk("starts", 32'd2, starts);
        chk("wakes", 32'd2, wakes);
        nap(3'h1, 1'b1);
        rdchk(adc_sleep_pkg::OFS_INT_STATUS, 32'h5, "other first");
        chk("no wake", 32'd2, wakes);
        chk("requests other", 32'd3, reqs);
        apb(1'b1, adc_sleep_pkg::OFS_INT_MASK, 32'h0);
        @(negedge clk_in);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, adc_sleep_pkg::OFS_INT_MASK, 32'h7);
        @(negedge clk_in);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, adc_sleep_pkg::OFS_INT_STATUS, 32'h7);
        for (int m = 2; m < 8; m++)
            nap(m[2:0], 1'b1);
        chk("starts other", 32'd3, starts);
        rdchk(adc_sleep_pkg::OFS_CTRL, 32'h5, "enable kept");
        chk("enable pin", 32'h1, {31'h0, en});
        apb(1'b1, adc_sleep_pkg::OFS_CTRL, 32'h4);
        apb(1'b1, adc_sleep_pkg::OFS_CTRL, 32'h5);
        rdchk(adc_sleep_pkg::OFS_STATUS, 32'h4, "ext pending");
        nap(3'h1, 1'b0);
        chk("ext starts", 32'd1, exts);
        rdchk(adc_sleep_pkg::OFS_STATUS, 32'h0, "ext used");
        apb(1'b1, adc_sleep_pkg::OFS_INT_STATUS, 32'h7);
        // manual start while awake: one conversion, completion only, no wake pulse
        apb(1'b1, adc_sleep_pkg::OFS_CTRL, 32'hD);
        repeat (CONV_CYC + 10) @(posedge clk_in);
        rdchk(adc_sleep_pkg::OFS_INT_STATUS, 32'h1, "manual done");
        rdchk(adc_sleep_pkg::OFS_CTRL, 32'h5, "start reads 0");
        chk("manual no wake", 32'd3, wakes);
        apb(1'b1, adc_sleep_pkg::OFS_INT_STATUS, 32'h7);
        apb(1'b1, adc_sleep_pkg::OFS_CTRL, 32'h4);
        nap(3'h1, 1'b1);
        chk("disabled", 32'd5, starts);
        chk("requests", 32'd5, reqs);
        chk("enable off", 32'h0, {31'h0, en});
        wrap_up();
    end
endmodule
